// >>> hdl/esm_level_gate.sv
`default_nettype none
module esm_level_gate (
    input wire logic valid_in,
    input wire logic nmi_in,
    input wire logic [5:0] level_in,
    input wire logic [5:0] threshold_in,
    output logic accept_out
);
    wire above;

    // Strictly greater: a request equal to the threshold is held off.
    assign above = level_in > threshold_in; // RQ6
    assign accept_out = valid_in & (nmi_in | above); // RQ6
endmodule // esm_level_gate
`default_nettype wire

// >>> hdl/esm_pkg.sv
`default_nettype none
package esm_pkg;
    // Field width, set count, masks and reset values of the status word.
    localparam int FIELD_W = 6;
    localparam int RS_SETS = 4;
    localparam logic [5:0] RS_MASK = 6'h03;
    localparam logic [5:0] NORMAL_RS = 6'h00;
    localparam logic [5:0] RESET_RS = 6'h00;
    localparam logic [5:0] RESET_IL = 6'h00;
    localparam logic RESET_IH = 1'b0;
    localparam logic RESET_EH = 1'b0;
    localparam logic FLAG_SET = 1'b1;

    typedef struct packed {
        logic [5:0] previous_register_set;
        logic [5:0] current_register_set;
        logic [5:0] il;
        logic ih;
        logic eh;
    } esm_status_t;

    typedef struct packed {
        logic valid;
        logic nmi;
        logic [5:0] level;
        logic [5:0] rs;
    } esm_irq_req_t;

    typedef enum logic [1:0] {
        ESM_EV_NONE,
        ESM_EV_SW,
        ESM_EV_EXC,
        ESM_EV_IRQ
    } esm_event_t;
endpackage
`default_nettype wire

// >>> hdl/esm_status.sv
// Operation
// RQ1: A read-only current register set field exists and clears to zero.
// RQ2: Current register set zero selects the normal register set.
// RQ3: Current register set one and above selects a shadow register set.
// RQ4: A noninterrupt exception forces the current register set to zero. An interrupt taken in the same cycle wins instead and loads its own set.
// RQ5: Set fields carry only the configured bits; upper bits read as zero.
// RQ6: A maskable interrupt is taken only when its level exceeds threshold.
// RQ7: Taking an interrupt from the controller sets the interrupt flag.
// RQ8: Any exception, breaks included, sets the exception handler flag.
// RQ9: On an exception the current set is copied to the previous set.
// RQ10: Unimplemented bits read as zero and act as zero.
// RQ11: Flags and threshold update on the clock edge of the commit.
`default_nettype none
module esm_status (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic sw_wr_in,
    input wire esm_pkg::esm_status_t sw_data_in,
    input wire logic exc_take_in,
    input wire esm_pkg::esm_irq_req_t irq_req_in,
    input wire logic irq_take_in,
    output logic irq_accept_out,
    output esm_pkg::esm_status_t status_out,
    output logic [esm_pkg::RS_SETS-1:0] rs_select_out,
    output logic shadow_active_out
);
    localparam int RS_BITS = $clog2(esm_pkg::RS_SETS);

    esm_pkg::esm_status_t status;
    esm_pkg::esm_status_t next_status;
    esm_pkg::esm_event_t ev;
    logic [RS_BITS-1:0] previous_register_set;
    logic [RS_BITS-1:0] current_register_set;
    logic [5:0] il;
    logic ih;
    logic eh;
    logic [esm_pkg::RS_SETS-1:0] rs_select;
    logic shadow_active;
    wire [5:0] prs_view;
    wire [5:0] crs_view;
    wire [esm_pkg::RS_SETS-1:0] next_rs_select;
    wire next_shadow;
    wire irq_commit;
    wire exc_commit;
    wire sw_commit;
    wire [5:0] irq_rs;
    wire [5:0] sw_prs;

    esm_level_gate u_gate (
        .valid_in(irq_req_in.valid),
        .nmi_in(irq_req_in.nmi),
        .level_in(irq_req_in.level),
        .threshold_in(status.il),
        .accept_out(irq_accept_out)
    );

    // An interrupt commit is only honoured for a request the gate passed.
    assign irq_commit = irq_take_in & irq_accept_out; // RQ6
    // Hardware events win over a software write in the same cycle so that
    // no exception entry is lost to a racing control-register write.
    assign exc_commit = exc_take_in & ~irq_commit; // RQ4 RQ8
    assign sw_commit = sw_wr_in & ~irq_commit & ~exc_take_in; // RQ1
    assign irq_rs = irq_req_in.rs & esm_pkg::RS_MASK; // RQ5 RQ10
    assign sw_prs = sw_data_in.previous_register_set & esm_pkg::RS_MASK; // RQ5 RQ10

    assign ev = irq_commit ? esm_pkg::ESM_EV_IRQ :
                exc_commit ? esm_pkg::ESM_EV_EXC :
                sw_commit ? esm_pkg::ESM_EV_SW : esm_pkg::ESM_EV_NONE;

    always_comb
    begin
        next_status = status;
        case (ev)
            esm_pkg::ESM_EV_IRQ:
            begin
                next_status.previous_register_set = status.current_register_set; // RQ9
                next_status.current_register_set = irq_rs; // RQ3
                next_status.il = irq_req_in.level; // RQ11
                next_status.ih = esm_pkg::FLAG_SET; // RQ7
                next_status.eh = esm_pkg::FLAG_SET; // RQ8
            end
            esm_pkg::ESM_EV_EXC:
            begin
                next_status.previous_register_set = status.current_register_set; // RQ9
                next_status.current_register_set = esm_pkg::NORMAL_RS; // RQ4
                next_status.eh = esm_pkg::FLAG_SET; // RQ8
            end
            esm_pkg::ESM_EV_SW:
            begin
                // The current set is never written by software.
                next_status.previous_register_set = sw_prs; // RQ1
                next_status.il = sw_data_in.il; // RQ6
                next_status.ih = sw_data_in.ih; // RQ7
                next_status.eh = sw_data_in.eh; // RQ8
            end
            default:
            begin
                next_status = status;
            end
        endcase
    end

    // Each field keeps its own register so reset and update read per field.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            previous_register_set <= esm_pkg::RESET_RS[RS_BITS-1:0];
        end
        else
        begin
            previous_register_set <= next_status.previous_register_set[RS_BITS-1:0]; // RQ9 RQ11
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            current_register_set <= esm_pkg::RESET_RS[RS_BITS-1:0]; // RQ1
        end
        else
        begin
            current_register_set <= next_status.current_register_set[RS_BITS-1:0]; // RQ4 RQ11
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            il <= esm_pkg::RESET_IL;
        end
        else
        begin
            il <= next_status.il; // RQ6 RQ11
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ih <= esm_pkg::RESET_IH;
        end
        else
        begin
            ih <= next_status.ih; // RQ7 RQ11
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            eh <= esm_pkg::RESET_EH;
        end
        else
        begin
            eh <= next_status.eh; // RQ8 RQ11
        end
    end

    // Bits beyond the configured sets have no flip-flop behind them, so
    // neither a write nor an event can make them read back as nonzero.
    genvar b;
    generate
        for (b = 0; b < esm_pkg::FIELD_W; b = b + 1)
        begin : g_bit
            if (b < RS_BITS)
            begin : g_used
                assign crs_view[b] = current_register_set[b];
                assign prs_view[b] = previous_register_set[b];
            end
            else
            begin : g_zero
                assign crs_view[b] = 1'b0; // RQ5 RQ10
                assign prs_view[b] = 1'b0; // RQ5 RQ10
            end
        end
    endgenerate

    assign status = {prs_view, crs_view, il, ih, eh}; // RQ5 RQ10

    // One select line per register set, set zero being the normal file.
    genvar g;
    generate
        for (g = 0; g < esm_pkg::RS_SETS; g = g + 1)
        begin : g_sel
            assign next_rs_select[g] = next_status.current_register_set == 6'(g); // RQ2 RQ3
        end
    endgenerate
    assign next_shadow = ~next_rs_select[0]; // RQ3

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rs_select <= {{(esm_pkg::RS_SETS-1){1'b0}}, 1'b1}; // RQ1 RQ2
        end
        else
        begin
            rs_select <= next_rs_select; // RQ2 RQ3
        end
    end

    // Kept as a flop of its own so the output carries no gate after it.
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            shadow_active <= 1'b0;
        end
        else
        begin
            shadow_active <= next_shadow; // RQ3
        end
    end

    assign status_out = status;
    assign rs_select_out = rs_select;
    assign shadow_active_out = shadow_active;
endmodule // esm_status
`default_nettype wire

// >>> tb/esm_irq_model.sv
`default_nettype none
module esm_irq_model (
    input wire logic mclk_in,
    input wire logic raise_in,
    input wire esm_pkg::esm_irq_req_t want_in,
    input wire logic taken_in,
    output var esm_pkg::esm_irq_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // A taken request with no new raise clears valid and shows the other fields inverted so stale data never passes.
    always_ff @(posedge mclk_in)
        if (raise_in)
            req_out <= want_in;
        else if (taken_in)
            req_out <= ~req_out & 14'h1fff;
endmodule // esm_irq_model
`default_nettype wire

// >>> tb/esm_properties.sv
`default_nettype none
module esm_properties (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic sw_wr_in,
    input wire esm_pkg::esm_status_t sw_data_in,
    input wire logic exc_take_in,
    input wire esm_pkg::esm_irq_req_t irq_req_in,
    input wire logic irq_take_in,
    input wire logic irq_accept_out,
    input wire esm_pkg::esm_status_t status_out,
    input wire logic [esm_pkg::RS_SETS-1:0] rs_select_out,
    input wire logic shadow_active_out
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic tk = irq_take_in & irq_accept_out;
    wire esm_pkg::esm_status_t s = status_out;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    property p_gate; irq_accept_out == (irq_req_in.valid &
        (irq_req_in.nmi | irq_req_in.level > s.il)); endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_exc; exc_take_in && !tk |=> !s.current_register_set && s.eh; endproperty
    a_exc: assert property (p_exc) else $error("exc");
    property p_prs; exc_take_in || tk |=> s.previous_register_set == $past(s.current_register_set); endproperty
    a_prs: assert property (p_prs) else $error("prs");
    property p_irq; tk |=> s.ih && s.il == $past(irq_req_in.level);
    endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_ro; sw_wr_in && !exc_take_in && !tk |=> $stable(s.current_register_set);
    endproperty
    a_ro: assert property (p_ro) else $error("ro");
    property p_msk; !s.current_register_set[5:2] && !s.previous_register_set[5:2]; endproperty
    a_msk: assert property (p_msk) else $error("msk");
    property p_sel; rs_select_out == 4'(4'h1 << s.current_register_set[1:0]); endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_shd; shadow_active_out == (s.current_register_set != 6'h00); endproperty
    a_shd: assert property (p_shd) else $error("shd");
endmodule // esm_properties
`default_nettype wire

// >>> tb/esm_status_tb.sv
`default_nettype none
module esm_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 0, rst_in = 1, sw_wr_in = 0, exc_take_in = 0;
    logic irq_take_in = 0, raise = 1, pend = 0, a, g, irq_accept_out;
    logic shadow_active_out;
    logic [3:0] rs_select_out;
    logic [24:0] seen;
    esm_pkg::esm_status_t sw_data_in = '0, status_out, m = '0;
    esm_pkg::esm_irq_req_t irq_req_in, want = '0;
    logic [24:0] q[$];
    logic qa[$];
    int n_fail = 0, compares = 0;
    initial forever #5 mclk_in = ~mclk_in;
    esm_irq_model pm (.mclk_in(mclk_in), .raise_in(raise),
        .want_in(want), .taken_in(irq_take_in), .req_out(irq_req_in));
    esm_status dut (.mclk_in(mclk_in), .rst_in(rst_in), .sw_wr_in(sw_wr_in),
        .sw_data_in(sw_data_in), .exc_take_in(exc_take_in),
        .irq_req_in(irq_req_in), .irq_take_in(irq_take_in),
        .irq_accept_out(irq_accept_out), .status_out(status_out),
        .rs_select_out(rs_select_out),
        .shadow_active_out(shadow_active_out));
    assign seen = {status_out, rs_select_out, shadow_active_out};
    task automatic chk(input string what, input logic [31:0] got, exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic run(input int n);
        repeat (n)
        begin
            @(posedge mclk_in);
            #1 raise = 1'($urandom);
            want = 14'($urandom);
            sw_data_in = 20'($urandom);
            {sw_wr_in, exc_take_in, irq_take_in} = 3'($urandom);
            g = irq_req_in.valid
                & (irq_req_in.nmi | irq_req_in.level > m.il);
            a = irq_take_in & g;
            qa.push_back(g);
            if (a)
                m = '{m.current_register_set, irq_req_in.rs & 6'h03, irq_req_in.level,
                    1'b1, 1'b1};
            else if (exc_take_in)
                m = '{m.current_register_set, 6'h00, m.il, m.ih, 1'b1};
            else if (sw_wr_in)
                m = '{sw_data_in.previous_register_set & 6'h03, m.current_register_set, sw_data_in.il,
                    sw_data_in.ih, sw_data_in.eh};
            if (sw_wr_in | exc_take_in | irq_take_in)
                q.push_back({m, 4'(4'h1 << m.current_register_set[1:0]), m.current_register_set != 6'h00});
        end
    endtask
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk_in) pend <= sw_wr_in | exc_take_in | irq_take_in;
    always @(negedge mclk_in)
    begin
        if (qa.size() > 0)
            chk("accept", 32'(irq_accept_out), 32'(qa.pop_front()));
        if (pend && q.size() > 0)
            chk("status", 32'(seen), 32'(q.pop_front()));
    end
    initial
    begin
        void'($urandom(32'hef01_5409));
        repeat (12) @(posedge mclk_in);
        #1 rst_in = 0;
        chk("reset", 32'(seen), 32'h0000_0002);
        run(300);
        @(posedge mclk_in);
        #1 {sw_wr_in, exc_take_in, irq_take_in} = 3'h0;
        rst_in = 1;
        repeat (2) @(posedge mclk_in);
        #1 rst_in = 0;
        m = '0;
        chk("reset", 32'(seen), 32'h0000_0002);
        run(200);
        @(posedge mclk_in);
        #1 {sw_wr_in, exc_take_in, irq_take_in} = 3'h0;
        @(posedge mclk_in);
        #1 chk("queue", 32'(q.size() + qa.size()), 32'h0000_0000);
        close_out();
    end
endmodule // esm_status_tb
bind esm_status esm_properties chk_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .sw_wr_in(sw_wr_in), .sw_data_in(sw_data_in),
    .exc_take_in(exc_take_in), .irq_req_in(irq_req_in),
    .irq_take_in(irq_take_in), .irq_accept_out(irq_accept_out),
    .status_out(status_out), .rs_select_out(rs_select_out),
    .shadow_active_out(shadow_active_out));
`default_nettype wire
